// ### ppd_pkg.sv
package ppd_pkg;
  // Port width and implemented pin positions
  localparam int          PPD_W         = 8;
  localparam logic [7:0]  PPD_PIN_MASK  = 8'hcf;  // Pins 7:6 and 3:0
  localparam logic [7:0]  PPD_IRQ_MASK  = 8'h0f;  // Interrupt-capable pins
  localparam int          PPD_RSVD_LO   = 4;      // Reserved field low bit
  localparam int          PPD_RSVD_HI   = 5;      // Reserved field high bit

  // Register byte offsets on the bus
  localparam logic [7:0]  PPD_OFF_DATA  = 8'h00;  // port_data_latch
  localparam logic [7:0]  PPD_OFF_DIR   = 8'h04;  // port_direction
  localparam logic [7:0]  PPD_OFF_PULL  = 8'h08;  // port_pull_enable
  localparam logic [7:0]  PPD_OFF_SLEW  = 8'h0c;  // port_slew_enable
  localparam logic [7:0]  PPD_OFF_DRIVE = 8'h10;  // port_drive_select
  localparam logic [7:0]  PPD_OFF_EDGE  = 8'h14;  // pin_edge_polarity_select
  localparam logic [7:0]  PPD_OFF_ISEL  = 8'h18;  // Pin interrupt select

  // Reset values
  localparam logic [7:0]  PPD_RST_REG   = 8'h00;
  localparam logic [31:0] PPD_RST_RDATA = 32'h0000_0000;

  // Bus encodings
  localparam logic [1:0]  PPD_HTRANS_NONSEQ = 2'h2;
  localparam logic        PPD_HRESP_OKAY    = 1'h0;
endpackage

// ### ppd_cfg_if.sv
`timescale 1ns/100ps
// Pin configuration from register file to pin control
interface ppd_cfg_if;
  import ppd_pkg::*;
  logic [PPD_W-1:0] dir;    // Direction, 1 = output
  logic [PPD_W-1:0] latch;  // Data latch
  logic [PPD_W-1:0] pull;   // Pull enable
  logic [PPD_W-1:0] slew;   // Slew limit enable
  logic [PPD_W-1:0] drive;  // High drive select
  logic [PPD_W-1:0] edge_pol; // 1 = rising edge / pull-down where isel is set
  logic [PPD_W-1:0] isel;   // Pin used as interrupt input
  modport src (output dir, latch, pull, slew, drive, edge_pol, isel);
  modport dst (input  dir, latch, pull, slew, drive, edge_pol, isel);
endinterface

// ### ppd_pin_ctrl.sv
`timescale 1ns/100ps
// Registered pad controls derived from the configuration
module ppd_pin_ctrl
  import ppd_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rstn_sync,
  ppd_cfg_if.dst                cfg,
  output logic [PPD_W-1:0]      pin_out,
  output logic [PPD_W-1:0]      pin_oe,
  output logic [PPD_W-1:0]      pin_pull_en,
  output logic [PPD_W-1:0]      pin_pull_dn,
  output logic [PPD_W-1:0]      pin_slew_en,
  output logic [PPD_W-1:0]      pin_drive_hi
);
  logic [PPD_W-1:0] out_en;    // Output pins among implemented ones
  logic [PPD_W-1:0] pull_act;  // Pull device actually on

  assign out_en   = cfg.dir & PPD_PIN_MASK;
  assign pull_act = cfg.pull & ~cfg.dir & PPD_PIN_MASK;

  // Driver enable and driven level
  always_ff @(posedge clk_sys or negedge rstn_sync) begin
    if (!rstn_sync) begin
      pin_oe  <= PPD_RST_REG;
      pin_out <= PPD_RST_REG;
    end else begin
      pin_oe  <= out_en;
      pin_out <= cfg.latch & out_en;
    end
  end

  // Pull device on/off and direction
  always_ff @(posedge clk_sys or negedge rstn_sync) begin
    if (!rstn_sync) begin
      pin_pull_en <= PPD_RST_REG;
      pin_pull_dn <= PPD_RST_REG;
    end else begin
      pin_pull_en <= pull_act;
      pin_pull_dn <= pull_act & cfg.edge_pol & cfg.isel & PPD_IRQ_MASK;
    end
  end

  // Slew and drive only mean something on outputs
  always_ff @(posedge clk_sys or negedge rstn_sync) begin
    if (!rstn_sync) begin
      pin_slew_en  <= PPD_RST_REG;
      pin_drive_hi <= PPD_RST_REG;
    end else begin
      pin_slew_en  <= cfg.slew & out_en;
      pin_drive_hi <= cfg.drive & out_en;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn_sync);

  a_pull_off_out:  assert property (
    (pin_pull_en & pin_oe) == 8'h00)
    else $error("pull device on while pin drives");
  a_pull_follows:  assert property (
    ##1 pin_pull_en == ($past(cfg.pull) & ~$past(cfg.dir) & PPD_PIN_MASK))
    else $error("pull enable not following register");
  a_pulldown_cond: assert property (
    |pin_pull_dn |-> |($past(cfg.isel) & $past(cfg.edge_pol)))
    else $error("pull-down without rising interrupt select");
  a_pull_dir_sel:  assert property (
    ##1 pin_pull_dn == ($past(pull_act) & $past(cfg.edge_pol)
                        & $past(cfg.isel) & PPD_IRQ_MASK))
    else $error("pull direction does not follow edge select");
  a_slew_input:    assert property (
    (pin_slew_en & ~pin_oe) == 8'h00)
    else $error("slew control active on an input");
  a_drive_input:   assert property (
    (pin_drive_hi & ~pin_oe) == 8'h00)
    else $error("drive select active on an input");
  a_oe_follows:    assert property (
    ##1 pin_oe == ($past(cfg.dir) & PPD_PIN_MASK))
    else $error("driver enable not following direction");
  a_no_leak_in:    assert property (
    (pin_out & ~pin_oe) == 8'h00)
    else $error("latch value on an input pin");
endmodule

// ### ppd_top.sv
`timescale 1ns/100ps
// Function
// - Direction bits 7:6,3:0 readable and writable
// - Direction 0: driver off, data reads pin
// - Direction 1: driver on, data reads latch
// - Bits 5:4 ignore writes, read zero
// - Pull enable bit switches pull device
// - Output pins keep pull device off
// - Pull-down only for rising-edge interrupt pins
// - Edge select picks pull-up or pull-down on interrupt-selected pins 3:0 only
// - Slew bit enables output slew limiting
// - Slew bit ignored on input pins
// - Data writes latch; outputs drive latch
// - Reset clears latch, pins inputs, no pulls
// - Drive bit selects strength, outputs only
module ppd_top
  import ppd_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic [ppd_pkg::PPD_W-1:0] pin_in,
  output logic [ppd_pkg::PPD_W-1:0]  pin_out,
  output logic [ppd_pkg::PPD_W-1:0]  pin_oe,
  output logic [ppd_pkg::PPD_W-1:0]  pin_pull_en,
  output logic [ppd_pkg::PPD_W-1:0]  pin_pull_dn,
  output logic [ppd_pkg::PPD_W-1:0]  pin_slew_en,
  output logic [ppd_pkg::PPD_W-1:0]  pin_drive_hi
);
  import ppd_pkg::*;

  // Register map decode kinds
  typedef enum {
    PPD_R_DATA,
    PPD_R_DIR,
    PPD_R_PULL,
    PPD_R_SLEW,
    PPD_R_DRIVE,
    PPD_R_EDGE,
    PPD_R_ISEL,
    PPD_R_NONE
  } ppd_reg_t;

  logic [1:0]       rst_sync_q;  // Reset release chain
  logic             rstn_sync;   // Synchronised reset
  logic [PPD_W-1:0] pin_meta_q;  // First pin sampling stage
  logic [PPD_W-1:0] pin_sync_q;  // Pin level safe to read
  logic             wr_pend_q;   // Write data phase pending
  logic [7:0]       wr_addr_q;   // Address of pending write
  logic             rd_take;     // Read address phase accepted
  logic             wr_take;     // Write address phase accepted
  logic [PPD_W-1:0] wr_byte;     // Written byte, pin bits only
  ppd_reg_t         wr_kind;     // Target of pending write
  logic [PPD_W-1:0] rd_val;      // Value for a read
  logic [PPD_W-1:0] dir_q;       // port_direction
  logic [PPD_W-1:0] latch_q;     // port_data_latch
  logic [PPD_W-1:0] pull_q;      // port_pull_enable
  logic [PPD_W-1:0] slew_q;      // port_slew_enable
  logic [PPD_W-1:0] drive_q;     // port_drive_select
  logic [PPD_W-1:0] edge_q;      // pin_edge_polarity_select
  logic [PPD_W-1:0] isel_q;      // Interrupt pin select
  logic [31:0]      hrdata_q;    // Registered read data
  logic             hreadyout_q; // Registered ready

  ppd_cfg_if cfg ();  // Configuration to pin control

  // Offset to register kind, used by read and write paths
  function automatic ppd_reg_t ppd_decode(input logic [7:0] off);
    ppd_reg_t k;
    k = PPD_R_NONE;
    unique case (off)
      PPD_OFF_DATA:  k = PPD_R_DATA;
      PPD_OFF_DIR:   k = PPD_R_DIR;
      PPD_OFF_PULL:  k = PPD_R_PULL;
      PPD_OFF_SLEW:  k = PPD_R_SLEW;
      PPD_OFF_DRIVE: k = PPD_R_DRIVE;
      PPD_OFF_EDGE:  k = PPD_R_EDGE;
      PPD_OFF_ISEL:  k = PPD_R_ISEL;
      default:       k = PPD_R_NONE;  // Unmapped offsets
    endcase
    return k;
  endfunction

  // Reset release; assertion is immediate, release takes two edges
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign rstn_sync = rst_sync_q[1];

  // Pin levels are asynchronous; two stages before anyone reads them
  always_ff @(posedge clk_sys or negedge rstn_sync) begin
    if (!rstn_sync) begin
      pin_meta_q <= PPD_RST_REG;
      pin_sync_q <= PPD_RST_REG;
    end else begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Address phase qualification
  assign rd_take = hsel & hready & (htrans == PPD_HTRANS_NONSEQ) & ~hwrite;
  assign wr_take = hsel & hready & (htrans == PPD_HTRANS_NONSEQ) & hwrite;
  assign wr_byte = hwdata[PPD_W-1:0] & PPD_PIN_MASK;
  assign wr_kind = wr_pend_q ? ppd_decode(wr_addr_q) : PPD_R_NONE;

  // Write address held until its data phase
  always_ff @(posedge clk_sys or negedge rstn_sync) begin
    if (!rstn_sync) begin
      wr_pend_q <= 1'h0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= wr_take;
      if (wr_take) begin
        wr_addr_q <= haddr[7:0];
      end
    end
  end

  // Direction register
  always_ff @(posedge clk_sys or negedge rstn_sync) begin
    if (!rstn_sync) begin
      dir_q <= PPD_RST_REG;
    end else if (wr_kind == PPD_R_DIR) begin
      dir_q <= wr_byte;
    end
  end

  // Data latch
  always_ff @(posedge clk_sys or negedge rstn_sync) begin
    if (!rstn_sync) begin
      latch_q <= PPD_RST_REG;
    end else if (wr_kind == PPD_R_DATA) begin
      latch_q <= wr_byte;
    end
  end

  // Pull, slew and drive controls
  always_ff @(posedge clk_sys or negedge rstn_sync) begin
    if (!rstn_sync) begin
      pull_q  <= PPD_RST_REG;
      slew_q  <= PPD_RST_REG;
      drive_q <= PPD_RST_REG;
    end else begin
      if (wr_kind == PPD_R_PULL) begin
        pull_q <= wr_byte;
      end
      if (wr_kind == PPD_R_SLEW) begin
        slew_q <= wr_byte;
      end
      if (wr_kind == PPD_R_DRIVE) begin
        drive_q <= wr_byte;
      end
    end
  end

  // Interrupt-side settings that steer pull direction
  always_ff @(posedge clk_sys or negedge rstn_sync) begin
    if (!rstn_sync) begin
      edge_q <= PPD_RST_REG;
      isel_q <= PPD_RST_REG;
    end else begin
      // edge select only on interrupt pins
      if (wr_kind == PPD_R_EDGE) begin
        edge_q <= wr_byte & PPD_IRQ_MASK;
      end
      // interrupt select only on interrupt pins
      if (wr_kind == PPD_R_ISEL) begin
        isel_q <= wr_byte & PPD_IRQ_MASK;
      end
    end
  end

  // Read value chosen in the address phase
  always_comb begin
    rd_val = PPD_RST_REG;
    unique case (ppd_decode(haddr[7:0]))
      // pin level for inputs, latch for outputs
      PPD_R_DATA:  rd_val = (dir_q & latch_q) | (~dir_q & pin_sync_q);
      PPD_R_DIR:   rd_val = dir_q;
      PPD_R_PULL:  rd_val = pull_q;
      PPD_R_SLEW:  rd_val = slew_q;
      PPD_R_DRIVE: rd_val = drive_q;
      PPD_R_EDGE:  rd_val = edge_q;
      PPD_R_ISEL:  rd_val = isel_q;
      PPD_R_NONE:  rd_val = PPD_RST_REG;  // Unmapped reads zero
    endcase
  end

  // Bus answer; zero wait states, so ready simply stays high
  always_ff @(posedge clk_sys or negedge rstn_sync) begin
    if (!rstn_sync) begin
      hrdata_q    <= PPD_RST_RDATA;
      hreadyout_q <= 1'h1;
    end else begin
      hreadyout_q <= 1'h1;
      if (rd_take) begin
        // reserved and upper bits read zero
        hrdata_q <= {24'h000000, rd_val & PPD_PIN_MASK};
      end
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = PPD_HRESP_OKAY;

  // Configuration handed to pin control
  assign cfg.dir      = dir_q;
  assign cfg.latch    = latch_q;
  assign cfg.pull     = pull_q;
  assign cfg.slew     = slew_q;
  assign cfg.drive    = drive_q;
  assign cfg.edge_pol = edge_q;
  assign cfg.isel     = isel_q;

  // Pad control flops
  ppd_pin_ctrl u_pin_ctrl (
    .clk_sys      (clk_sys),
    .rstn_sync    (rstn_sync),
    .cfg          (cfg),
    .pin_out      (pin_out),
    .pin_oe       (pin_oe),
    .pin_pull_en  (pin_pull_en),
    .pin_pull_dn  (pin_pull_dn),
    .pin_slew_en  (pin_slew_en),
    .pin_drive_hi (pin_drive_hi)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn_sync);

  // Read address phase to the data register
  sequence s_data_read;
    rd_take && haddr[7:0] == PPD_OFF_DATA;
  endsequence
  // Write address phase to the direction register
  sequence s_dir_write;
    wr_take && haddr[7:0] == PPD_OFF_DIR;
  endsequence

  a_dir_readback:  assert property (
    s_dir_write ##1 1'b1 |=> dir_q == ($past(hwdata[7:0]) & PPD_PIN_MASK))
    else $error("direction register not written");
  a_read_input:    assert property (
    s_data_read |=> (hrdata_q[7:0] & ~$past(dir_q))
                    == ($past(pin_sync_q) & ~$past(dir_q) & PPD_PIN_MASK))
    else $error("input pin read wrong level");
  a_read_latch:    assert property (
    s_data_read |=> (hrdata_q[7:0] & $past(dir_q))
                    == ($past(latch_q) & $past(dir_q) & PPD_PIN_MASK))
    else $error("output pin read not the latch");
  a_rsvd_zero:     assert property (
    hrdata_q[31:8] == 24'h000000 &&
    hrdata_q[PPD_RSVD_HI:PPD_RSVD_LO] == 2'h0)
    else $error("reserved read bits not zero");
  a_latch_store:   assert property (
    wr_kind == PPD_R_DATA |=> latch_q == $past(wr_byte) ##2
    (pin_out & pin_oe) == (latch_q & pin_oe))
    else $error("data write not stored or driven");
  a_reset_clear:   assert property (
    $rose(rstn_sync) |-> latch_q == 8'h00 && dir_q == 8'h00
                         && pull_q == 8'h00)
    else $error("reset left port configured");
  a_slew_store:    assert property (
    wr_kind == PPD_R_SLEW && wr_byte[0] && dir_q[0] |-> ##2 pin_slew_en[0])
    else $error("slew enable not reaching pad");
  a_drive_dir:     assert property (
    wr_kind == PPD_R_DIR && wr_byte[7] && drive_q[7] |-> ##2 pin_drive_hi[7])
    else $error("drive select not applied to new output");
  a_ctrl_readback: assert property (
    rd_take && haddr[7:0] == PPD_OFF_PULL |=> hrdata_q[7:0] == $past(pull_q))
    else $error("pull enable readback wrong");
  a_ready_ok:      assert property (
    hreadyout && hresp == PPD_HRESP_OKAY)
    else $error("bus answer not ready OKAY");
endmodule

// ### ppd_pad_model.sv
`timescale 1ns/100ps
// Board around the port: outside drivers, pad pulls and floating lines
module ppd_pad_model
  import ppd_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic [PPD_W-1:0] pin_out,
  input  wire logic [PPD_W-1:0] pin_oe,
  input  wire logic [PPD_W-1:0] pin_pull_en,
  input  wire logic [PPD_W-1:0] pin_pull_dn,
  input  wire logic [PPD_W-1:0] ext_en,
  input  wire logic [PPD_W-1:0] ext_val,
  output logic      [PPD_W-1:0] pin_in
);
  logic [PPD_W-1:0] float_q = 8'h55;  // Undriven lines wander every cycle

  // Toggle so a floating pin never settles to a lucky value
  always @(posedge clk_sys) begin
    float_q <= ~float_q;
  end

  // Own driver first, then an outside driver, then pull, else floating
  always_comb begin
    for (int i = 0; i < PPD_W; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else if (pin_pull_en[i]) begin
        pin_in[i] = ~pin_pull_dn[i];  // Pull-down gives 0, pull-up 1
      end else begin
        pin_in[i] = float_q[i];
      end
    end
  end
endmodule

// ### ppd_top_tb.sv
`timescale 1ns/100ps
// Self-checking bench for the port pin control block
module ppd_top_tb;
  import ppd_pkg::*;
  logic             clk_sys = 1'b0;  // 10 MHz system clock
  logic             rstn    = 1'b1;  // Async reset, active low; falls at 0
  logic             hsel    = 1'b0;
  logic [31:0]      haddr   = 32'h0;
  logic [1:0]       htrans  = 2'h0;
  logic             hwrite  = 1'b0;
  logic [2:0]       hsize   = 3'h2;  // Word transfers only
  logic [31:0]      hwdata  = 32'h0;
  logic             hready;          // Single slave: bus ready is hreadyout
  logic [31:0]      hrdata;
  logic             hreadyout;
  logic             hresp;
  logic [PPD_W-1:0] pin_in, pin_out, pin_oe, pin_pull_en;
  logic [PPD_W-1:0] pin_pull_dn, pin_slew_en, pin_drive_hi;
  logic [PPD_W-1:0] ext_en  = 8'h00;  // Outside drivers; the pad model lets an output's own driver win
  logic [PPD_W-1:0] ext_val = 8'h00;
  int               num_errors  = 0;
  int               comparisons = 0;
  logic [31:0]      rd;

  always #50 clk_sys = ~clk_sys;
  assign hready = hreadyout;

  ppd_top i_ppd_top (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en),
    .pin_pull_dn(pin_pull_dn), .pin_slew_en(pin_slew_en),
    .pin_drive_hi(pin_drive_hi));

  ppd_pad_model i_ppd_pad_model (.clk_sys(clk_sys), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pull_en(pin_pull_en), .pin_pull_dn(pin_pull_dn),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  // Compare and count; the bench never trusts an unknown
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic results;
    if (num_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Next edge with hready high, bounded so a stuck slave is reported
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hready !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 50) begin
      check(32'h0, 32'h1);
    end
  endtask

  // One single word transfer: address phase, then data phase
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [7:0] wd, output logic [31:0] rdat);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= PPD_HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy();
    rdat = hrdata;
    check({31'h0, hresp}, {31'h0, PPD_HRESP_OKAY});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] dummy;
    xfer(1'b1, a, d, dummy);
  endtask

  // Reads a register and compares it at once
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 8'h00, rd);
    check(rd, exp);
  endtask

  // Let pad outputs update and pin inputs pass the synchroniser
  task automatic settle;
    repeat (4) @(posedge clk_sys);
  endtask

  // Reset with pads and all registers cleared
  task automatic t_reset;
    rstn    <= 1'b0;
    ext_en  <= 8'hff;  // Hold pins low so a data read is defined
    ext_val <= 8'h00;
    repeat (10) @(posedge clk_sys);
    check({pin_oe, pin_out, pin_pull_en, pin_slew_en}, 32'h0);
    check({16'h0, pin_pull_dn, pin_drive_hi}, 32'h0);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int a = 0; a <= 8'h18; a += 4) begin
      rd_chk(a[7:0], PPD_RST_RDATA);
    end
    // Outputs read the latch, which reset must have cleared
    wr(PPD_OFF_DIR, 8'hcf);
    rd_chk(PPD_OFF_DATA, PPD_RST_RDATA);
    wr(PPD_OFF_DIR, 8'h00);
    ext_en <= 8'h00;
  endtask

  // Control bits read back, reserved bits and unmapped place ignored
  task automatic t_readback;
    logic [7:0] offs [4];
    offs = '{PPD_OFF_DIR, PPD_OFF_PULL, PPD_OFF_SLEW, PPD_OFF_DRIVE};
    foreach (offs[i]) begin
      wr(offs[i], 8'hff);
      rd_chk(offs[i], {24'h0, PPD_PIN_MASK});
      wr(offs[i], 8'h42);
      rd_chk(offs[i], 32'h42);
      wr(offs[i], 8'h00);
    end
    wr(8'h1c, 8'hff);
    rd_chk(8'h1c, 32'h0);
  endtask

  // Outputs drive the latch, inputs read the pin
  task automatic t_data;
    ext_en  <= 8'hcf;
    ext_val <= 8'h80;
    wr(PPD_OFF_DIR, 8'h0f);
    wr(PPD_OFF_DATA, 8'ha5);
    settle();
    check({16'h0, pin_oe, pin_out}, 32'h0f05);
    rd_chk(PPD_OFF_DATA, 32'h85);
    // Pins 3 and 1 go input and read high although their latch is low
    ext_val <= 8'h4a;
    wr(PPD_OFF_DIR, 8'h05);
    settle();
    check({16'h0, pin_oe, pin_out}, 32'h0505);
    rd_chk(PPD_OFF_DATA, 32'h4f);
    ext_en <= 8'h00;
  endtask

  // Pull on only for inputs; pull-down only for rising-edge interrupt pins
  task automatic t_pull;
    wr(PPD_OFF_DIR, 8'h0f);
    wr(PPD_OFF_PULL, 8'hff);
    wr(PPD_OFF_EDGE, 8'h0f);
    wr(PPD_OFF_ISEL, 8'h05);
    settle();
    check({16'h0, pin_pull_en, pin_pull_dn}, 32'hc000);
    wr(PPD_OFF_DIR, 8'h00);
    settle();
    check({16'h0, pin_pull_en, pin_pull_dn}, 32'hcf05);
    rd_chk(PPD_OFF_DATA, 32'hca);
    wr(PPD_OFF_PULL, 8'h00);
    settle();
    check({24'h0, pin_pull_en}, 32'h0);
  endtask

  // Slew and drive act on outputs only
  task automatic t_slew_drive;
    wr(PPD_OFF_DIR, 8'h00);
    wr(PPD_OFF_SLEW, 8'hff);
    wr(PPD_OFF_DRIVE, 8'hff);
    settle();
    check({16'h0, pin_slew_en, pin_drive_hi}, 32'h0000);
    wr(PPD_OFF_DIR, 8'hc3);
    settle();
    check({16'h0, pin_slew_en, pin_drive_hi}, 32'hc3c3);
    wr(PPD_OFF_SLEW, 8'h00);
    settle();
    check({16'h0, pin_slew_en, pin_drive_hi}, 32'h00c3);
    wr(PPD_OFF_SLEW, 8'h01);
    settle();
    check({16'h0, pin_slew_en, pin_drive_hi}, 32'h01c3);
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #(100 * 20000);
    num_errors++;
    results();
  end

  // Main sequence, ending with a reset in mid-run
  initial begin
    t_reset();
    t_readback();
    t_data();
    t_pull();
    t_slew_drive();
    wr(PPD_OFF_DATA, 8'hff);
    t_reset();
    results();
  end
endmodule
